// ===== blv_consts.vh
// Constants for the brightness limit value two evaluator
`ifndef BLV_CONSTS_VH
`define BLV_CONSTS_VH
`define BLV_CLK_HZ 50000000
`define BLV_TICK_CYCLES (`BLV_CLK_HZ / 1)
`define BLV_CYCLE_STEP_S 10
`define BLV_CYCLE_MAX 120
`define BLV_THR_MIN_KLX 3
`define BLV_THR_MAX_KLX 105
`define BLV_THR_STEP_KLX 5
`define BLV_HYST_STEPS 16
`define BLV_DLY_STEPS 14
// Mode codes
`define BLV_M_EX_ON_UN_OFF 4'h0
`define BLV_M_EX_OFF_UN_ON 4'h1
`define BLV_M_UN_ON_EX_OFF 4'h2
`define BLV_M_UN_OFF_EX_ON 4'h3
`define BLV_M_EX_ON 4'h4
`define BLV_M_EX_OFF 4'h5
`define BLV_M_UN_ON 4'h6
`define BLV_M_UN_OFF 4'h7
`define BLV_M_UNH_OFF 4'h8
`define BLV_M_UNH_ON 4'h9
`define BLV_M_EXH_OFF 4'ha
`define BLV_M_EXH_ON 4'hb
// External threshold source
`define BLV_EXT_NONE 2'h0
`define BLV_EXT_16 2'h1
`define BLV_EXT_8 2'h2
`endif

// ===== blv_timer.v
// One-second tick seconds counter with restart
`timescale 1ns/1ns
`default_nettype none
`include "blv_consts.vh"
module blv_timer (
   input wire clk,
   input wire srst,
   input wire restart,
   input wire tick,
   output wire [12:0] secs
);
   reg [12:0] secs_reg;
   // Counts ticks; saturates so long waits do not wrap
   always @(posedge clk) begin
      if (srst || restart) begin
         secs_reg <= 13'h0000;
      end else if (tick && secs_reg != 13'h1fff) begin
         secs_reg <= secs_reg + 13'h0001;
      end
   end
   assign secs = secs_reg;
endmodule
`default_nettype wire

// ===== blv_limit.v
// Brightness limiting value two evaluator
// How it works
// - Hysteresis none, 1-5, 10-100 klx
// - Four two-sided modes with hysteresis
// - Eight one-sided modes, other side silent
// - Act only on crossing in mode direction
// - External 2-byte or 1-byte threshold option
// - Switch-on delay before accepting 1
// - Cyclic sends old 0 during on delay
// - Switch-off delay before accepting 0
// - Cyclic sends old 1 during off delay
// - No-telegram condition suppresses cyclic sends
// - Send-on-change sends every output change
// - Without send-on-change, only cyclic sends
// - Cycle interval is setting times 10s
// - Cycle setting zero disables cyclic sends
// - No change send, zero cycle: silent
// - Internal threshold 3 to 105 klx
// - Download discards external threshold value
`timescale 1ns/1ns
`default_nettype none
`include "blv_consts.vh"
module blv_limit (
   input wire clk,
   input wire srst,
   input wire [15:0] bright_klx,
   input wire bright_valid,
   input wire [4:0] thr_sel,
   input wire [3:0] hyst_sel,
   input wire [3:0] mode_sel,
   input wire [1:0] ext_sel,
   input wire [15:0] ext_value,
   input wire ext_valid,
   input wire download,
   input wire [3:0] on_dly_sel,
   input wire [3:0] off_dly_sel,
   input wire send_on_change,
   input wire [6:0] cycle_sel,
   output reg tx_valid,
   output reg tx_value,
   output reg out_state
);
   // ***********************************************
   // Setting decode
   // ***********************************************
   // Hysteresis table in klx
   function [6:0] hyst_klx;
      input [3:0] sel;
      reg [7:0] prod;
      begin
         // Steps above five are tens of klx, at most 100 fits seven bits
         prod = {4'h0, sel - 4'h5} * 8'h0a;
         if (sel <= 4'h5) begin
            hyst_klx = {3'h0, sel};
         end else begin
            hyst_klx = prod[6:0];
         end
      end
   endfunction
   // Delay table in seconds
   function [12:0] dly_secs;
      input [3:0] sel;
      begin
         case (sel)
            4'h0: dly_secs = 13'd0;
            4'h1: dly_secs = 13'd1;
            4'h2: dly_secs = 13'd3;
            4'h3: dly_secs = 13'd5;
            4'h4: dly_secs = 13'd10;
            4'h5: dly_secs = 13'd15;
            4'h6: dly_secs = 13'd30;
            4'h7: dly_secs = 13'd60;
            4'h8: dly_secs = 13'd180;
            4'h9: dly_secs = 13'd300;
            4'ha: dly_secs = 13'd600;
            4'hb: dly_secs = 13'd900;
            4'hc: dly_secs = 13'd1800;
            default: dly_secs = 13'd3600;
         endcase
      end
   endfunction

   // ***********************************************
   // Threshold selection
   // ***********************************************
   reg [15:0] ext_thr_reg;
   reg ext_have_reg;
   wire [6:0] int_thr;
   wire [9:0] thr_mul;
   wire [15:0] threshold_level;
   wire [6:0] hyst;
   assign thr_mul = {5'h00, thr_sel} * 10'h005;
   assign int_thr = (thr_sel == 5'h0) ? 7'd3 :
      (thr_sel > 5'd20) ? 7'd105 : thr_mul[6:0];
   assign hyst = hyst_klx(hyst_sel); // decoded here, applied in the crossing limits
   always @(posedge clk) begin
      if (srst || download) begin
         ext_thr_reg <= 16'h0000;
         ext_have_reg <= 1'b0;
      end else if (ext_valid && ext_sel != `BLV_EXT_NONE) begin
         ext_thr_reg <= (ext_sel == `BLV_EXT_8) ? {8'h00, ext_value[7:0]} : ext_value;
         ext_have_reg <= 1'b1;
      end
   end
   // fall back to internal until received
   assign threshold_level = (ext_sel != `BLV_EXT_NONE && ext_have_reg) ?
      ext_thr_reg : {9'h000, int_thr};

   // ***********************************************
   // Crossing detection
   // ***********************************************
   wire [16:0] up_lim;
   wire [16:0] dn_lim;
   wire two_up;
   reg above_reg;
   reg below_reg;
   reg primed_reg;
   reg cross_up;
   reg cross_dn;
   // Modes 0,1,4,5,8,9 use upper edge at LV, lower at LV-hyst
   assign two_up = (mode_sel == `BLV_M_EX_ON_UN_OFF) || (mode_sel == `BLV_M_EX_OFF_UN_ON) ||
      (mode_sel == `BLV_M_EX_ON) || (mode_sel == `BLV_M_EX_OFF) ||
      (mode_sel == `BLV_M_UNH_OFF) || (mode_sel == `BLV_M_UNH_ON);
   assign up_lim = two_up ? {1'b0, threshold_level} : {1'b0, threshold_level} + {10'h000, hyst};
   assign dn_lim = two_up ?
      (({1'b0, threshold_level} > {10'h000, hyst}) ? {1'b0, threshold_level} - {10'h000, hyst}
         : 17'h00000) : {1'b0, threshold_level};
   always @* begin
      cross_up = bright_valid && primed_reg && !above_reg && ({1'b0, bright_klx} > up_lim);
      cross_dn = bright_valid && primed_reg && !below_reg && ({1'b0, bright_klx} < dn_lim);
   end
   always @(posedge clk) begin
      if (srst) begin
         above_reg <= 1'b0;
         below_reg <= 1'b0;
         primed_reg <= 1'b0;
      end else if (bright_valid) begin
         primed_reg <= 1'b1;
         if ({1'b0, bright_klx} > up_lim) begin
            above_reg <= 1'b1;
            below_reg <= 1'b0;
         end else if ({1'b0, bright_klx} < dn_lim) begin
            above_reg <= 1'b0;
            below_reg <= 1'b1;
         end
      end
   end

   // ***********************************************
   // Mode actions
   // ***********************************************
   reg act_go;
   reg act_val;
   reg silent_next;
   always @* begin
      act_go = 1'b0;
      act_val = 1'b0;
      silent_next = 1'b0;
      case (mode_sel)
         `BLV_M_EX_ON_UN_OFF, `BLV_M_UN_OFF_EX_ON: begin
            act_go = cross_up | cross_dn;
            act_val = cross_up;
         end
         `BLV_M_EX_OFF_UN_ON, `BLV_M_UN_ON_EX_OFF: begin
            act_go = cross_up | cross_dn;
            act_val = cross_dn;
         end
         `BLV_M_EX_ON, `BLV_M_EX_OFF, `BLV_M_EXH_ON, `BLV_M_EXH_OFF: begin
            act_go = cross_up;
            act_val = (mode_sel == `BLV_M_EX_ON) || (mode_sel == `BLV_M_EXH_ON);
            silent_next = cross_dn;
         end
         `BLV_M_UN_ON, `BLV_M_UN_OFF, `BLV_M_UNH_ON, `BLV_M_UNH_OFF: begin
            act_go = cross_dn;
            act_val = (mode_sel == `BLV_M_UN_ON) || (mode_sel == `BLV_M_UNH_ON);
            silent_next = cross_up;
         end
         default: begin
            act_go = 1'b0;
         end
      endcase
   end

   // ***********************************************
   // Delay and cycle timing
   // ***********************************************
   reg [25:0] tick_cnt_reg;
   reg tick_reg;
   reg pend_reg;
   reg pend_val_reg;
   reg silent_reg;
   reg cyc_restart;
   wire [12:0] dly_secs_now;
   wire [12:0] cyc_secs;
   wire [12:0] cyc_target;
   wire [13:0] cyc_prod;
   wire dly_done;
   localparam [25:0] TICK_LAST = `BLV_TICK_CYCLES - 1;
   always @(posedge clk) begin
      if (srst || tick_cnt_reg == TICK_LAST) begin
         tick_cnt_reg <= 26'h0000000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 26'h0000001;
      end
      tick_reg <= !srst && tick_cnt_reg == TICK_LAST;
   end
   // delay restarts on each new request
   blv_timer u_dly (
      .clk(clk),
      .srst(srst),
      .restart(act_go),
      .tick(tick_reg),
      .secs(dly_secs_now)
   );
   blv_timer u_cyc (
      .clk(clk),
      .srst(srst),
      .restart(cyc_restart),
      .tick(tick_reg),
      .secs(cyc_secs)
   );
   assign dly_done = pend_reg && (dly_secs_now >=
      (pend_val_reg ? dly_secs(on_dly_sel) : dly_secs(off_dly_sel)));
   // interval is setting times ten
   // Largest setting gives 1270 s, inside thirteen bits
   assign cyc_prod = {7'h00, cycle_sel} * 14'h000a;
   assign cyc_target = cyc_prod[12:0];
   always @* begin
      cyc_restart = (cycle_sel == 7'h00) || (cyc_secs >= cyc_target);
   end
   // reset leaves output 0, nothing pending
   always @(posedge clk) begin
      if (srst) begin
         pend_reg <= 1'b0;
         pend_val_reg <= 1'b0;
         out_state <= 1'b0;
         silent_reg <= 1'b0;
         tx_valid <= 1'b0;
         tx_value <= 1'b0;
      end else begin
         tx_valid <= 1'b0;
         if (silent_next) begin
            silent_reg <= 1'b1;
         end else if (act_go) begin
            silent_reg <= 1'b0;
         end
         if (act_go) begin
            pend_reg <= (act_val != out_state);
            pend_val_reg <= act_val;
         end else if (dly_done) begin
            // old value held until on delay ends
            // old value held until off delay ends
            pend_reg <= 1'b0;
            out_state <= pend_val_reg;
            if (send_on_change) begin
               tx_valid <= 1'b1;
               tx_value <= pend_val_reg;
            end
         end
         if (cyc_restart && cycle_sel != 7'h00 && !silent_reg &&
               !(act_go || dly_done)) begin
            tx_valid <= 1'b1;
            tx_value <= out_state;
         end
      end
   end
endmodule
`default_nettype wire

// ===== blv_limit_chk.sv
// Assertion checker for the brightness limit evaluator
`timescale 1ns/1ns
`default_nettype none
`include "blv_consts.vh"
module blv_limit_chk (
   input wire clk,
   input wire srst,
   input wire bright_valid,
   input wire [3:0] mode_sel,
   input wire [3:0] on_dly_sel,
   input wire [3:0] off_dly_sel,
   input wire send_on_change,
   input wire [6:0] cycle_sel,
   input wire tx_valid,
   input wire tx_value,
   input wire out_state
);
   // ****************
   // Output properties
   // ****************
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   rst_clear_a: assert property (disable iff (1'b0) srst |=> !out_state && !tx_valid)
      else $error("outputs set after reset");
   tx_pulse_a: assert property (tx_valid |=> !tx_valid)
      else $error("telegram pulse too long");
   chg_send_a: assert property ($changed(out_state) && send_on_change &&
      $past(send_on_change) |-> tx_valid && tx_value == out_state) else $error("change not sent");
   // Telegram always carries the accepted state, old value while a delay runs
   tx_value_a: assert property (tx_valid |-> tx_value == out_state)
      else $error("telegram value differs from state");
   silent_a: assert property ((!send_on_change && cycle_sel == 7'h00)[*3] |-> !tx_valid)
      else $error("telegram while silent");
   one_side_a: assert property ((mode_sel == `BLV_M_EX_ON && off_dly_sel == 4'h0)[*3]
      |-> !$fell(out_state)) else $error("one-sided mode turned off");
   idle_mode_a: assert property ((mode_sel > 4'hb)[*3] |-> $stable(out_state))
      else $error("unused mode changed state");
   cause_a: assert property ((on_dly_sel == 4'h0 && off_dly_sel == 4'h0)[*3] ##0
      $changed(out_state) |-> $past(bright_valid, 2)) else $error("state change without sample");
endmodule
bind blv_limit blv_limit_chk u_chk (.clk(clk), .srst(srst), .bright_valid(bright_valid),
   .mode_sel(mode_sel), .on_dly_sel(on_dly_sel), .off_dly_sel(off_dly_sel), .tx_value(tx_value),
   .send_on_change(send_on_change), .cycle_sel(cycle_sel), .tx_valid(tx_valid), .out_state(out_state));
`default_nettype wire

// ===== blv_bus_model.sv
// Bus-side partner: counts telegrams, writes external thresholds
`timescale 1ns/1ns
`default_nettype none
module blv_bus_model (
   input wire logic clk,
   input wire logic tx_valid,
   output logic [15:0] ext_value = 16'h0000,
   output logic ext_valid = 1'b0
);
   int n_tel = 0;
   // Count every telegram seen on the bus
   always @(posedge clk) if (tx_valid) n_tel <= n_tel + 1;
   task send_thr(input logic [15:0] v);
      @(negedge clk);
      ext_value <= v;
      ext_valid <= 1'b1;
      @(negedge clk);
      ext_valid <= 1'b0;
      ext_value <= ~v; // Stale value must not look valid
   endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the brightness limit evaluator
`timescale 1ns/1ns
`default_nettype none
`include "blv_consts.vh"
module testbench;
   logic clk = 1'b0, srst = 1'b1, bright_valid = 1'b0, download = 1'b0, send_on_change = 1'b1;
   logic [15:0] bright_klx = 16'h0000;
   logic [3:0] hyst_sel = 4'h0, mode_sel = 4'h0, on_dly_sel = 4'h0, off_dly_sel = 4'h0;
   logic [1:0] ext_sel = 2'h0;
   logic cur = 1'b0;
   wire logic [15:0] ext_value;
   wire logic ext_valid, tx_valid, tx_value, out_state;
   int fails = 0, n_compared = 0, cycles = 0, exp_tel = 0;
   // Per mode: state after under, over, under, starting from on
   logic [2:0] tbl [0:12] = '{3'h2, 3'h5, 3'h5, 3'h2, 3'h7, 3'h4, 3'h7, 3'h0, 3'h0, 3'h7, 3'h4,
      3'h7, 3'h7};
   blv_limit u_dut (.clk(clk), .srst(srst), .bright_klx(bright_klx), .bright_valid(bright_valid),
      .thr_sel(5'h02), .hyst_sel(hyst_sel), .mode_sel(mode_sel), .ext_sel(ext_sel),
      .ext_value(ext_value), .ext_valid(ext_valid), .download(download), .on_dly_sel(on_dly_sel),
      .off_dly_sel(off_dly_sel), .send_on_change(send_on_change), .cycle_sel(7'h00),
      .tx_valid(tx_valid), .tx_value(tx_value), .out_state(out_state));
   blv_bus_model u_bus (.clk(clk), .tx_valid(tx_valid), .ext_value(ext_value),
      .ext_valid(ext_valid));
   always #10 clk = ~clk;
   // Hang guard well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         complete_run();
      end
   end
   task complete_run();
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task do_reset();
      @(negedge clk);
      srst <= 1'b1;
      repeat (10) @(negedge clk);
      srst <= 1'b0;
      cur = 1'b0;
      cmp(out_state, 1'b0);
   endtask
   // One brightness sample, then state and telegram count
   task step(input logic [15:0] v, input logic e);
      @(negedge clk);
      bright_klx <= v;
      bright_valid <= 1'b1;
      @(negedge clk);
      bright_valid <= 1'b0;
      bright_klx <= ~v;
      repeat (4) @(negedge clk);
      if (e !== cur && send_on_change) begin
         exp_tel++;
         cmp(tx_value, e);
      end
      cur = e;
      cmp(out_state, e);
      cmp(u_bus.n_tel, exp_tel);
   endtask
   initial begin
      // Every mode, threshold 10, from an on state
      for (int m = 0; m < 13; m++) begin
         do_reset();
         mode_sel = 4'h0;
         step(16'h5, 1'b0);
         step(16'hf, 1'b1);
         mode_sel = m[3:0];
         step(16'h5, tbl[m][2]);
         step(16'hf, tbl[m][1]);
         step(16'h5, tbl[m][0]);
      end
      do_reset();
      mode_sel = `BLV_M_UN_OFF_EX_ON;
      hyst_sel = 4'h6;
      step(16'hf, 1'b0);
      step(16'h15, 1'b1);
      step(16'h9, 1'b0);
      step(16'h14, 1'b0);
      do_reset();
      mode_sel = `BLV_M_EX_ON_UN_OFF;
      hyst_sel = 4'h0;
      ext_sel = `BLV_EXT_16;
      u_bus.send_thr(16'h0028);
      step(16'h1e, 1'b0);
      step(16'h29, 1'b1);
      ext_sel = `BLV_EXT_8;
      u_bus.send_thr(16'hff14);
      step(16'h13, 1'b0);
      step(16'h15, 1'b1);
      download = 1'b1;
      @(negedge clk);
      download = 1'b0;
      step(16'h9, 1'b0);
      step(16'hb, 1'b1);
      do_reset();
      ext_sel = `BLV_EXT_NONE;
      on_dly_sel = 4'h1;
      step(16'h5, 1'b0);
      step(16'hf, 1'b0);
      step(16'h5, 1'b0);
      on_dly_sel = 4'h0;
      off_dly_sel = 4'h1;
      step(16'hf, 1'b1);
      step(16'h5, 1'b1);
      do_reset();
      off_dly_sel = 4'h0;
      send_on_change = 1'b0;
      step(16'h5, 1'b0);
      step(16'hf, 1'b1);
      step(16'h5, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
